/* mcg_top.sv */
// Master clock generator: bypass prescalers, digital PLL, CPU clock halving, APB registers
//
// Behaviour
// [R1] Source select with upper bit zero: master = oscillator / ((idiv+1)*(odiv+1)).
// [R2] Bypass with both dividers zero: master follows oscillator level directly.
// [R3] Input divider holds up to 3, output divider up to 15.
// [R4] Source select 11 enables PLL: oscillator*(mul+1)/((idiv+1)*(odiv+1)).
// [R5] PLL frequency adjusts gradually while locking, never in abrupt steps.
// [R6] PLL VCO output passes the output prescaler dividing by odiv plus one.
// [R7] Two-bit VCO band selects range; value 11 is reserved for software.
// [R8] One halve bit makes CPU clock master or master/2; system clock equals CPU.
// [R9] Bypass or PLL generation is chosen from the clock generation control register.
// [R10] Input divider field is two bits, output divider field four bits wide.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "mcg_params.svh"
module mcg_top (
    input  wire logic        pclk,             // APB clock, 125 MHz
    input  wire logic        presetn,          // Asynchronous reset, active low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB enable
    input  wire logic        pwrite,           // APB write
    input  wire logic [11:0] paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error on unmapped address
    input  wire logic        oscillator_input, // Oscillator pin
    output logic             master_clk,       // Master clock level
    output logic             cpu_clk,          // CPU clock level
    output logic             sys_clk,          // Peripheral system clock level
    output logic             pll_locked        // PLL reference count matched
);
    logic [1:0] clock_source_select_q;
    logic [1:0] input_divider_q;
    logic [3:0] output_divider_q;
    logic [4:0] feedback_multiplier_q;
    logic [1:0] vco_band_select_q;
    logic       cpu_clock_halve_q;

    logic        ctrl_hit;
    logic        stat_hit;
    logic        wr_ctrl;
    logic [31:0] rd_word;
    logic        band_err;

    mcg_pkg::mcg_mode_t mode;

    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic osc_rise;

    logic ref_lvl;
    logic ref_rise;
    logic pre_src;
    logic pre_rise;
    logic mc_rise;

    logic [7:0] vco_half_q;
    logic [7:0] vco_cnt_q;
    logic       vco_q;
    logic       vco_rise_q;
    logic [5:0] vco_edges_q;
    logic [5:0] mul_target;
    logic [7:0] half_min;
    logic [7:0] half_max;

    assign ctrl_hit = (paddr == `MCG_CTRL_OFS);
    assign stat_hit = (paddr == `MCG_STAT_OFS);
    assign wr_ctrl  = psel && penable && pready && pwrite && ctrl_hit;
    assign band_err = (vco_band_select_q == 2'h3);

    // Configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_source_select_q <= `MCG_SRC_RST;
            input_divider_q       <= `MCG_IDIV_RST;
            output_divider_q      <= `MCG_ODIV_RST;
            feedback_multiplier_q <= `MCG_MUL_RST;
            vco_band_select_q     <= `MCG_BAND_RST;
            cpu_clock_halve_q     <= `MCG_HALVE_RST;
        end else if (wr_ctrl) begin
            clock_source_select_q <= pwdata[`MCG_SRC_LSB +: 2];  // see [R9]
            input_divider_q       <= pwdata[`MCG_IDIV_LSB +: 2];  // see [R10] see [R3]
            output_divider_q      <= pwdata[`MCG_ODIV_LSB +: 4];  // see [R10] see [R3]
            feedback_multiplier_q <= pwdata[`MCG_MUL_LSB +: 5];
            vco_band_select_q     <= pwdata[`MCG_BAND_LSB +: 2];
            cpu_clock_halve_q     <= pwdata[`MCG_HALVE_BIT];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        if (ctrl_hit) begin
            rd_word[`MCG_SRC_LSB +: 2]  = clock_source_select_q;
            rd_word[`MCG_IDIV_LSB +: 2] = input_divider_q;
            rd_word[`MCG_ODIV_LSB +: 4] = output_divider_q;
            rd_word[`MCG_MUL_LSB +: 5]  = feedback_multiplier_q;
            rd_word[`MCG_BAND_LSB +: 2] = vco_band_select_q;
            rd_word[`MCG_HALVE_BIT]     = cpu_clock_halve_q;
        end else if (stat_hit) begin
            rd_word[`MCG_STAT_LOCK_BIT]     = pll_locked;
            rd_word[`MCG_STAT_BERR_BIT]     = band_err;
            rd_word[`MCG_STAT_HALF_LSB +: 8] = vco_half_q;
        end
    end

    // No wait state: answer is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !ctrl_hit && !stat_hit;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // Oscillator pin synchroniser; edge detect reads the second and third stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= oscillator_input;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end
    assign osc_rise = osc_s2_q && !osc_s3_q;

    // Code 10 is undefined; it falls back to bypass
    assign mode = (clock_source_select_q == 2'h3) ? mcg_pkg::MCG_PLL : mcg_pkg::MCG_BYPASS;  // see [R9]

    mcg_divider u_in_div (
        .clk      (pclk),
        .rst_n    (presetn),
        .src      (osc_s2_q),
        .src_rise (osc_rise),
        .div      ({2'h0, input_divider_q}),
        .div_out  (ref_lvl),
        .div_rise (ref_rise)
    );

    // Reserved band runs with the slowest band limits
    always_comb begin
        case (vco_band_select_q)  // see [R7]
            2'h1:    begin half_min = `MCG_B1_MIN; half_max = `MCG_B1_MAX; end
            2'h2:    begin half_min = `MCG_B2_MIN; half_max = `MCG_B2_MAX; end
            default: begin half_min = `MCG_B0_MIN; half_max = `MCG_B0_MAX; end
        endcase
    end

    // VCO: toggles every vco_half_q plus one cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_cnt_q  <= 8'h00;
            vco_q      <= 1'b0;
            vco_rise_q <= 1'b0;
        end else if (mode == mcg_pkg::MCG_PLL && vco_cnt_q >= vco_half_q) begin
            vco_cnt_q  <= 8'h00;
            vco_q      <= !vco_q;
            vco_rise_q <= !vco_q;
        end else begin
            vco_cnt_q  <= (mode == mcg_pkg::MCG_PLL) ? vco_cnt_q + 8'h01 : 8'h00;
            vco_rise_q <= 1'b0;
        end
    end

    assign mul_target = {1'b0, feedback_multiplier_q} + 6'h01;

    // Loop compares VCO rises per reference period with mul plus one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_edges_q <= 6'h00;
        end else if (ref_rise || mode != mcg_pkg::MCG_PLL) begin
            vco_edges_q <= {5'h00, vco_rise_q};
        end else if (vco_rise_q && vco_edges_q != 6'h3f) begin
            vco_edges_q <= vco_edges_q + 6'h01;
        end
    end

    // One count per step keeps the frequency slewing smoothly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_half_q <= `MCG_HALF_RST;
            pll_locked <= 1'b0;
        end else if (mode != mcg_pkg::MCG_PLL) begin
            pll_locked <= 1'b0;
        end else if (vco_half_q < half_min) begin
            vco_half_q <= vco_half_q + 8'h01;  // see [R5] see [R7]
            pll_locked <= 1'b0;
        end else if (vco_half_q > half_max) begin
            vco_half_q <= vco_half_q - 8'h01;  // see [R5] see [R7]
            pll_locked <= 1'b0;
        end else if (ref_rise) begin
            pll_locked <= (vco_edges_q == mul_target);
            if (vco_edges_q < mul_target && vco_half_q > half_min) begin
                vco_half_q <= vco_half_q - 8'h01;  // see [R5] see [R4]
            end else if (vco_edges_q > mul_target && vco_half_q < half_max) begin
                vco_half_q <= vco_half_q + 8'h01;  // see [R5] see [R4]
            end
        end
    end

    always_comb begin
        case (mode)
            mcg_pkg::MCG_PLL: begin
                pre_src  = vco_q;  // see [R4] see [R6]
                pre_rise = vco_rise_q;
            end
            default: begin
                pre_src  = ref_lvl;  // see [R1]
                pre_rise = ref_rise;
            end
        endcase
    end

    mcg_divider u_out_div (
        .clk      (pclk),
        .rst_n    (presetn),
        .src      (pre_src),
        .src_rise (pre_rise),
        .div      (output_divider_q),
        .div_out  (master_clk),
        .div_rise (mc_rise)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk <= 1'b0;
            sys_clk <= 1'b0;
        end else if (cpu_clock_halve_q) begin
            if (mc_rise) begin
                cpu_clk <= !cpu_clk;  // see [R8]
                sys_clk <= !cpu_clk;
            end
        end else begin
            cpu_clk <= master_clk;  // see [R8]
            sys_clk <= master_clk;
        end
    end

    a_apb_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready && pslverr == $past(!ctrl_hit && !stat_hit))
        else $error("APB answer not one cycle after setup");

    a_ctrl_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> clock_source_select_q == $past(pwdata[1:0])  // see [R9]
            && output_divider_q == $past(pwdata[7:4]))
        else $error("control write not stored");

    a_bypass_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == mcg_pkg::MCG_BYPASS && input_divider_q == 2'h0 && output_divider_q == 4'h0)[*3]  // see [R2]
        |-> master_clk == $past(osc_s2_q, 2))
        else $error("bypass master clock does not follow oscillator");

    a_vco_slew_step: assert property (@(posedge pclk) disable iff (!presetn)  // see [R5]
        1'b1 |=> (vco_half_q == $past(vco_half_q) || vco_half_q == $past(vco_half_q) + 8'h01
            || vco_half_q == $past(vco_half_q) - 8'h01))
        else $error("VCO period jumped by more than one step");

    a_band_keep_range: assert property (@(posedge pclk) disable iff (!presetn)  // see [R7]
        (mode == mcg_pkg::MCG_PLL && $stable(vco_band_select_q)
            && vco_half_q >= half_min && vco_half_q <= half_max)
        |=> $stable(vco_band_select_q) |-> (vco_half_q >= half_min && vco_half_q <= half_max))
        else $error("VCO period left its band");

    a_cpu_full_rate: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(cpu_clock_halve_q) |-> cpu_clk == $past(master_clk) && sys_clk == cpu_clk)  // see [R8]
        else $error("CPU clock not equal to master clock");

    a_cpu_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(cpu_clock_halve_q) && cpu_clk != $past(cpu_clk)) |-> $past(mc_rise))  // see [R8]
        else $error("halved CPU clock toggled without master rise");

    a_lock_on_match: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pll_locked) |-> $past(ref_rise && vco_edges_q == mul_target && mode == mcg_pkg::MCG_PLL))  // see [R4]
        else $error("lock flag set without count match");

    a_pll_mode_only: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == mcg_pkg::MCG_BYPASS)[*2] |-> !pll_locked && !vco_rise_q)  // see [R1]
        else $error("PLL active in bypass mode");
endmodule

/* mcg_params.svh */
// Register offsets, field positions, reset values and band limits of the master clock generator
`ifndef MCG_PARAMS_SVH
`define MCG_PARAMS_SVH

`define MCG_CTRL_OFS     12'h000
`define MCG_STAT_OFS     12'h004

`define MCG_SRC_LSB      0
`define MCG_IDIV_LSB     2
`define MCG_ODIV_LSB     4
`define MCG_MUL_LSB      8
`define MCG_BAND_LSB     13
`define MCG_HALVE_BIT    16

`define MCG_STAT_LOCK_BIT 0
`define MCG_STAT_BERR_BIT 1
`define MCG_STAT_HALF_LSB 8

`define MCG_SRC_RST      2'h0
`define MCG_IDIV_RST     2'h0
`define MCG_ODIV_RST     4'h0
`define MCG_MUL_RST      5'h03
`define MCG_BAND_RST     2'h0
`define MCG_HALVE_RST    1'h0
`define MCG_HALF_RST     8'h20

// VCO half period limits in pclk cycles per band
`define MCG_B0_MIN       8'h14
`define MCG_B0_MAX       8'h28
`define MCG_B1_MIN       8'h0a
`define MCG_B1_MAX       8'h14
`define MCG_B2_MIN       8'h04
`define MCG_B2_MAX       8'h0a

`endif

/* mcg_pkg.sv */
// Types shared by the master clock generator
package mcg_pkg;
    typedef enum logic [1:0] {
        MCG_BYPASS = 2'b01,
        MCG_PLL    = 2'b10
    } mcg_mode_t;
endpackage

/* mcg_divider.sv */
// Prescaler dividing a sampled clock level by div plus one
`timescale 1ns/100ps
module mcg_divider (
    input  wire logic       clk,      // System clock
    input  wire logic       rst_n,    // Asynchronous reset, active low
    input  wire logic       src,      // Source clock level
    input  wire logic       src_rise, // Source rising edge pulse
    input  wire logic [3:0] div,      // Divide by div plus one
    output logic            div_out,  // Divided clock level
    output logic            div_rise  // Divided rising edge pulse
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       wrap;

    // Counter may exceed a freshly lowered divisor, so wrap on >=
    assign wrap  = (cnt_q >= div);
    assign cnt_d = wrap ? 4'h0 : cnt_q + 4'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (src_rise) begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_out  <= 1'b0;
            div_rise <= 1'b0;
        end else if (div == 4'h0) begin
            div_out  <= src;      // see [R2]
            div_rise <= src_rise;
        end else begin
            div_rise <= src_rise && wrap;
            if (src_rise) begin
                div_out <= (cnt_d <= {1'b0, div[3:1]});  // see [R1]
            end
        end
    end

    a_div_cnt_range: assert property (@(posedge clk) disable iff (!rst_n)
        ($stable(div) && cnt_q <= div) |=> cnt_q <= $past(div))  // see [R3]
        else $error("prescaler count beyond divisor");

    a_div_rise_high: assert property (@(posedge clk) disable iff (!rst_n)
        div_rise |-> div_out)  // see [R6]
        else $error("prescaler rise pulse without high level");
endmodule

/* mcg_top_test.sv */
// Self-checking bench for the master clock generator
`timescale 1ns/100ps
`include "mcg_params.svh"
module mcg_top_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        oscillator_input;
    logic        master_clk;
    logic        cpu_clk;
    logic        sys_clk;
    logic        pll_locked;
    int          miscompares;
    int          n_tests;
    int          osc_h;
    int          osc_l;
    int          osc_cnt;
    int          sys_diff;
    int          cycles;

    mcg_top dut (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .oscillator_input (oscillator_input),
        .master_clk       (master_clk),
        .cpu_clk          (cpu_clk),
        .sys_clk          (sys_clk),
        .pll_locked       (pll_locked)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Oscillator made in whole pclk cycles so expected periods are exact
    always @(posedge pclk) begin
        if (osc_cnt >= osc_h + osc_l - 1) osc_cnt <= 0;
        else osc_cnt <= osc_cnt + 1;
        oscillator_input <= (osc_cnt < osc_h);
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (presetn && sys_clk !== cpu_clk) sys_diff <= sys_diff + 1;
        if (cycles == 60000) begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compares %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int g;
        g = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            g++;
        end while (pready !== 1'b1 && g < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (g >= 50) chk("pready wait", 32'h1, 32'h0);
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? master_clk : cpu_clk;
    endfunction

    // Cycles over n periods and high cycles of the last one; first call after a change discards
    task automatic meas(input int sel, input int n, output int per, output int hi);
        int r;
        int g;
        int h;
        logic p;
        per = 0;
        hi = 0;
        h = 0;
        r = 0;
        g = 0;
        p = pick(sel);
        while (r <= n && g < 20000) begin
            @(posedge pclk);
            #1;
            g++;
            if (r > 0) per++;
            if (pick(sel) && !p) begin
                r++;
                hi = h;
                h = 0;
            end
            if (pick(sel)) h++;
            p = pick(sel);
        end
    endtask

    logic [31:0] q;
    logic        e;
    int          per;
    int          hi;
    int          prev;
    int          tb [4][3] = '{'{0, 0, 0}, '{1, 1, 0}, '{0, 0, 2}, '{1, 3, 14}};

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        osc_h = 6;
        osc_l = 10;
        miscompares = 0;
        n_tests = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `MCG_CTRL_OFS, 0, q, e);
        chk("ctrl reset", 32'h00000300, q);
        apb(0, `MCG_STAT_OFS, 0, q, e);
        chk("stat reset", 32'h00002000, q & 32'h0000ff03);
        apb(1, 12'h008, 32'hffffffff, q, e);
        chk("unmapped write error", 32'h1, {31'h0, e});
        apb(0, 12'h008, 0, q, e);
        chk("unmapped read error", 32'h1, {31'h0, e});
        chk("unmapped read data", 32'h0, q);
        apb(1, `MCG_CTRL_OFS, 32'hffffffff, q, e);
        chk("mapped write error", 32'h0, {31'h0, e});
        apb(0, `MCG_CTRL_OFS, 0, q, e);
        chk("ctrl field widths", 32'h00017fff, q);
        // Bypass: both source codes with upper bit zero, dividers up to idiv 3 and odiv 14
        foreach (tb[i]) begin
            apb(1, `MCG_CTRL_OFS, 32'h300 | (tb[i][2] << 4) | (tb[i][1] << 2) | tb[i][0], q, e);
            meas(0, 1, per, hi);
            meas(0, 2, per, hi);
            chk("bypass period", 32'(32 * (tb[i][1] + 1) * (tb[i][2] + 1)), 32'(per));
            if (i == 0) chk("bypass high time", 32'd6, 32'(hi));
            if (i == 0) meas(1, 2, per, hi);
            if (i == 0) chk("cpu period unhalved", 32'd32, 32'(per));
        end
        apb(1, `MCG_CTRL_OFS, 32'h00010300, q, e);
        meas(1, 1, per, hi);
        meas(1, 2, per, hi);
        chk("cpu period halved", 32'd64, 32'(per));
        chk("sys equals cpu", 32'h0, 32'(sys_diff));
        // PLL: osc 224 cycles, multiplier 3, VCO ideally 56 cycles
        osc_h = 112;
        osc_l = 112;
        repeat (500) @(posedge pclk);
        apb(1, `MCG_CTRL_OFS, 32'h00000303, q, e);
        apb(0, `MCG_STAT_OFS, 0, q, e);
        prev = q[15:8];
        repeat (600) begin
            apb(0, `MCG_STAT_OFS, 0, q, e);
            chk("half period step", 32'h1, 32'(q[15:8] <= prev + 1 && q[15:8] + 1 >= prev));
            prev = q[15:8];
        end
        per = 0;
        while (pll_locked !== 1'b1 && per < 4000) begin
            @(posedge pclk);
            per++;
        end
        chk("pll locked", 32'h1, {31'h0, pll_locked});
        meas(0, 1, per, hi);
        meas(0, 4, per, hi);
        chk("pll period", 32'h1, 32'(per >= 204 && per <= 244));
        apb(1, `MCG_CTRL_OFS, 32'h00000313, q, e);
        meas(0, 1, per, hi);
        meas(0, 4, per, hi);
        chk("pll prescaled period", 32'h1, 32'(per >= 408 && per <= 488));
        for (int b = 0; b < 4; b++) begin
            apb(1, `MCG_CTRL_OFS, 32'h00000303 | (b << 13), q, e);
            apb(0, `MCG_STAT_OFS, 0, q, e);
            chk("reserved band flag", 32'(b == 3), {31'h0, q[1]});
        end
        apb(1, `MCG_CTRL_OFS, 32'h00000300, q, e);
        stop_test();
    end
endmodule
